/* File: design/sps_pkg.sv */
// Package of constants and types shared by both ends of the phase sequencer
package sps_pkg;
  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RESET_MIN_NS    = 10_000;
  localparam int unsigned STEP_PULSE_NS   = 10_000;
  localparam int unsigned STEP_MAX_HZ     = 50_000;
  localparam int unsigned STEP_PERIOD_NS  = 1_000_000_000 / STEP_MAX_HZ;
  localparam int unsigned DIR_SETUP_NS    = 6_250;
  localparam int unsigned MODE_SETUP_NS   = 5_000;
  // Least times round up to whole cycles
  localparam int unsigned RESET_CYC  = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_CYC  = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PERIOD_CYC = (STEP_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIR_CYC    = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MODE_CYC   = (MODE_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_CYC  = (DIR_CYC > MODE_CYC) ? DIR_CYC
                                                            : MODE_CYC;
  localparam int unsigned CNT_W      = 12;

  // ==========================================================================
  // Excitation pattern
  // ==========================================================================
  localparam int unsigned POS_W      = 3;
  localparam logic [2:0]  POS_RESET  = 3'h0;
  localparam logic [2:0]  POS_ONE    = 3'h1;
  localparam logic [2:0]  POS_TWO    = 3'h2;
  // Phase bit order {phase_b_inv, phase_b, phase_a_inv, phase_a}
  localparam logic [3:0]  PHASE_OFF  = 4'h0;

  // Half-step table, eight positions; even positions are two-phase-on
  function automatic logic [3:0] sps_phase_of(input logic [2:0] pos);
    unique case (pos)
      3'h0: sps_phase_of = 4'h9;
      3'h1: sps_phase_of = 4'h1;
      3'h2: sps_phase_of = 4'h3;
      3'h3: sps_phase_of = 4'h2;
      3'h4: sps_phase_of = 4'h6;
      3'h5: sps_phase_of = 4'h4;
      3'h6: sps_phase_of = 4'hC;
      3'h7: sps_phase_of = 4'h8;
    endcase
  endfunction : sps_phase_of

  // ==========================================================================
  // Host command register map (host's own registers)
  // ==========================================================================
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STEPS_ADDR  = 4'h4;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h8;
  localparam int unsigned CTRL_DIR_BIT   = 0;
  localparam int unsigned CTRL_MODE_BIT  = 1;
  localparam int unsigned CTRL_EN_BIT    = 2;
  localparam int unsigned CTRL_RST_BIT   = 3;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_RDY_BIT   = 1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0004;

  typedef enum logic [1:0] {SPS_IDLE, SPS_HIGH, SPS_LOW} sps_step_t;
endpackage : sps_pkg

/* File: design/sps_if.sv */
// Pin-level interface between the host controller and the phase sequencer
`timescale 1ns/10ps
`default_nettype none
interface sps_if;
  logic       step_clk;
  logic       rotation_dir_in;
  logic       mode_in;
  logic       reset_n_in;
  logic       enable_in;
  logic       phase_a_out;
  logic       phase_a_inv_out;
  logic       phase_b_out;
  logic       phase_b_inv_out;

  modport host (
    output step_clk, rotation_dir_in, mode_in, reset_n_in, enable_in,
    input  phase_a_out, phase_a_inv_out, phase_b_out, phase_b_inv_out
  );
  modport dev (
    input  step_clk, rotation_dir_in, mode_in, reset_n_in, enable_in,
    output phase_a_out, phase_a_inv_out, phase_b_out, phase_b_inv_out
  );
endinterface : sps_if
`default_nettype wire

/* File: design/sps_device.sv */
// Phase-distribution sequencer: device end of the stepper link
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R1] Reset starts pattern with first phase on
// [R2] Host holds reset low at least 10 us
// [R3] Step clock to 50 kHz, 10 us pulses
// [R4] Advance and sample only on step rise
// [R5] Direction input picks forward or reverse
// [R6] Direction stable 6.25 us around step edge
// [R7] Enable low forces all phases off
// [R8] Enable low holds the sequence position
// [R9] Enable high resumes from held position
// [R10] Mode 0 full-step, mode 1 half-step
// [R11] Mode stable 5 us around step edge
// [R12] Half-step leaves each phase off quarter time; the table here leaves each phase off in five of eight states
// [R13] Reset low clears state, phases off
// [R14] Four two-phase or eight alternating states
// [R15] Mode change applies at next edge
module sps_device
  import sps_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic CE,
  sps_if.dev        LINK,
  output logic      STEP_SEEN,
  output logic      PHASE_ON
);
  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic       step_prev_reg;
  logic [4:0] pins;

  assign pins = {LINK.step_clk, LINK.rotation_dir_in, LINK.mode_in,
                 LINK.reset_n_in, LINK.enable_in};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else if (CE) begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
    end
  end

  // Slot of each pin in the synchroniser vectors, as packed into pins
  localparam int unsigned PIN_EN   = 0;
  localparam int unsigned PIN_RST  = 1;
  localparam int unsigned PIN_MODE = 2;
  localparam int unsigned PIN_DIR  = 3;
  localparam int unsigned PIN_STEP = 4;

  logic step_s, dir_s, mode_s, rst_n_s, en_s, step_rise;
  assign step_s    = sync_reg[PIN_STEP];
  assign dir_s     = sync_reg[PIN_DIR];
  assign mode_s    = sync_reg[PIN_MODE];
  assign rst_n_s   = sync_reg[PIN_RST];
  assign en_s      = sync_reg[PIN_EN];
  assign step_rise = step_s & ~step_prev_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      step_prev_reg <= 1'b0;
    end else if (CE) begin
      step_prev_reg <= step_s;
    end
  end

  // ==========================================================================
  // Position counter
  // ==========================================================================
  // Full-step uses even positions only; an odd position left by half-step
  // moves to the next even one so the pattern stays continuous.
  logic [2:0] pos_reg;
  logic [2:0] pos_next;
  logic [2:0] stride;

  always_comb begin
    stride = mode_s ? POS_ONE : POS_TWO; // R10 R14
    if (!mode_s && pos_reg[0]) begin
      stride = POS_ONE; // R15
    end
    if (dir_s) begin
      pos_next = pos_reg - stride; // R5
    end else begin
      pos_next = pos_reg + stride; // R5
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pos_reg <= POS_RESET;
    end else if (CE) begin
      if (!rst_n_s) begin
        pos_reg <= POS_RESET; // R1 R13
      end else if (step_rise && en_s) begin
        pos_reg <= pos_next; // R4 R8 R9 R15
      end
    end
  end

  // ==========================================================================
  // Phase outputs
  // ==========================================================================
  logic [3:0] phase_reg;
  logic       phase_on_reg;
  logic       seen_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_reg <= PHASE_OFF;
    end else if (CE) begin
      if (!rst_n_s || !en_s) begin
        phase_reg <= PHASE_OFF; // R7 R13
      end else begin
        phase_reg <= sps_phase_of(pos_reg); // R12 R14
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      seen_reg <= 1'b0;
    end else if (CE) begin
      seen_reg <= step_rise && en_s && rst_n_s;
    end
  end

  // Every pattern has a phase on, so drive follows the run condition and
  // the status pin stays in step with the phase flip-flops
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_on_reg <= 1'b0;
    end else if (CE) begin
      phase_on_reg <= rst_n_s && en_s; // R7 R13
    end
  end

  assign LINK.phase_a_out     = phase_reg[0];
  assign LINK.phase_a_inv_out = phase_reg[1];
  assign LINK.phase_b_out     = phase_reg[2];
  assign LINK.phase_b_inv_out = phase_reg[3];
  assign STEP_SEEN            = seen_reg;
  assign PHASE_ON             = phase_on_reg;
endmodule : sps_device
`default_nettype wire

/* File: design/sps_host.sv */
// Host controller end: AXI4-Lite command registers driving the step pins
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sps_host
  import sps_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  sps_if.host              LINK,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  // ==========================================================================
  // AXI4-Lite write side
  // ==========================================================================
  logic [31:0] ctrl_reg;
  logic [15:0] steps_reg;
  logic [3:0]  aw_reg;
  logic        aw_have_reg, w_have_reg;
  logic [31:0] wd_reg;
  logic        wstrb0_reg, ctrl_wr;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        do_write, load_steps, busy;
  logic        rst_hold_reg;
  logic [CNT_W-1:0] rcnt_reg;

  assign S_AXI_AWREADY = ~aw_have_reg & ~bvalid_reg;
  assign S_AXI_WREADY  = ~w_have_reg & ~bvalid_reg;
  assign do_write      = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign load_steps    = do_write && aw_reg == REG_STEPS_ADDR && !busy;
  // Strobe is kept with the data, since W may be taken before AW
  assign ctrl_wr       = do_write && aw_reg == REG_CTRL_ADDR && wstrb0_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= 4'h0;
      wd_reg      <= 32'h0000_0000;
      wstrb0_reg  <= 1'b0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_reg      <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        wd_reg     <= S_AXI_WDATA;
        wstrb0_reg <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (aw_reg == REG_CTRL_ADDR || aw_reg == REG_STEPS_ADDR)
                      ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;

  // Byte strobes honoured on the control word; low lane carries the bits
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET_VAL;
    end else if (CE && ctrl_wr) begin
      ctrl_reg <= {28'h0000000, wd_reg[3:0]};
    end
  end

  // ==========================================================================
  // Reset pulse generator
  // ==========================================================================
  // Setting the reset bit launches a low pulse of at least the minimum
  // width; the pin is also low out of system reset so power-up is covered.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rcnt_reg     <= CNT_W'(RESET_CYC); // R1
      rst_hold_reg <= 1'b1;
    end else if (CE) begin
      if (ctrl_wr && wd_reg[CTRL_RST_BIT]) begin
        rcnt_reg     <= CNT_W'(RESET_CYC); // R2
        rst_hold_reg <= 1'b1;
      end else if (rcnt_reg != '0) begin
        rcnt_reg <= rcnt_reg - 1'b1;
      end else begin
        rst_hold_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Step generator
  // ==========================================================================
  // Direction and mode are latched only while idle, so they never move
  // near an edge: setup before the rise, hold through the low phase.
  sps_step_t        st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [15:0]      left_reg;
  logic             step_reg, dir_reg, mode_reg;

  assign busy = (st_reg != SPS_IDLE) || (left_reg != 16'h0000);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg   <= SPS_IDLE;
      cnt_reg  <= '0;
      left_reg <= 16'h0000;
      step_reg <= 1'b0;
      dir_reg  <= 1'b0;
      mode_reg <= 1'b0;
    end else if (CE) begin
      if (load_steps) begin
        left_reg <= wd_reg[15:0];
      end
      unique case (st_reg)
        SPS_IDLE: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (left_reg != 16'h0000 && !rst_hold_reg) begin
            dir_reg  <= ctrl_reg[CTRL_DIR_BIT];
            mode_reg <= ctrl_reg[CTRL_MODE_BIT];
            cnt_reg  <= CNT_W'(SETUP_CYC); // R6 R11
            st_reg   <= SPS_HIGH;
          end
        end
        SPS_HIGH: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            step_reg <= ~step_reg;
            if (step_reg) begin
              cnt_reg <= CNT_W'(PERIOD_CYC - PULSE_CYC); // R3
              st_reg  <= SPS_LOW;
              left_reg <= left_reg - 16'h0001;
            end else begin
              cnt_reg <= CNT_W'(PULSE_CYC); // R3
            end
          end
        end
        SPS_LOW: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            st_reg <= SPS_IDLE; // R6 R11
          end
        end
        default: begin
          st_reg <= SPS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read side and pins
  // ==========================================================================
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  assign S_AXI_ARREADY = ~rvalid_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= RESP_OKAY;
        unique case (S_AXI_ARADDR)
          REG_CTRL_ADDR:   rdata_reg <= ctrl_reg;
          REG_STEPS_ADDR:  rdata_reg <= {16'h0000, left_reg};
          REG_STATUS_ADDR: rdata_reg <= {30'h0, ~rst_hold_reg, busy};
          default: begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

  assign LINK.step_clk        = step_reg;
  assign LINK.rotation_dir_in = dir_reg;
  assign LINK.mode_in         = mode_reg;
  assign LINK.reset_n_in      = ~rst_hold_reg;
  assign LINK.enable_in       = ctrl_reg[CTRL_EN_BIT];
endmodule : sps_host
`default_nettype wire

/* File: tb/sps_sva.sv */
// Assertions on the pins between the host and the sequencer
`timescale 1ns/10ps
`default_nettype none
module sps_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic step_clk,
  input wire logic mode_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic phase_a_out,
  input wire logic phase_a_inv_out,
  input wire logic phase_b_out,
  input wire logic phase_b_inv_out,
  input wire logic STEP_SEEN
);
  // ==========
  // Pin views
  // ==========
  wire logic [3:0] ph = {phase_b_inv_out, phase_b_out,
                         phase_a_inv_out, phase_a_out};
  wire logic       run = enable_in && reset_n_in;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Phases land within a cycle of the pulse, so ##3 is settled
  sequence s_full; STEP_SEEN && !mode_in; endsequence
  sequence s_half; STEP_SEEN && mode_in; endsequence

  // ==========
  // Checks
  // ==========
  a_reset_off: assert property ((!reset_n_in)[*5] |-> ph == 4'h0)
    else $error("phase driven during link reset");
  a_enable_off: assert property ((!enable_in)[*5] |-> ph == 4'h0)
    else $error("phase driven while disabled");
  a_first_phase: assert property (
    $rose(reset_n_in) && enable_in |-> ##[1:6] ph == 4'h9)
    else $error("pattern did not start at first position");
  a_step_taken: assert property (
    $rose(step_clk) && run |-> ##[1:8] STEP_SEEN)
    else $error("step edge not taken");
  a_hold_off: assert property (STEP_SEEN |-> run)
    else $error("step taken while held");
  a_step_moves: assert property (STEP_SEEN |-> ##3 ph != $past(ph, 5))
    else $error("pattern did not advance");
  a_full_two: assert property (s_full |-> ##3 $countones(ph) == 2)
    else $error("full step left other than two phases on");
  a_half_one: assert property (
    s_half |-> ##3 $countones(ph ^ $past(ph, 5)) == 1)
    else $error("half step changed other than one phase");
endmodule : sps_sva
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the host and sequencer pair
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sps_pkg::*;
;
  logic        CLK, RST_N;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        step_seen, phase_on;
  logic [3:0]  wstrb;
  int          err_total, check_count, seed, pos, v, cdir, cmode;
  int          seen = 0;
  logic [3:0]  tbl [$] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8};

  sps_if link ();
  wire logic [3:0] ph = {link.phase_b_inv_out, link.phase_b_out,
                         link.phase_a_inv_out, link.phase_a_out};

  sps_host u_sps_host (.CLK, .RST_N, .CE(1'b1), .LINK(link.host),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  sps_device u_sps_device (.CLK, .RST_N, .CE(1'b1), .LINK(link.dev),
    .STEP_SEEN(step_seen), .PHASE_ON(phase_on));
  sps_sva u_sva (.CLK, .RST_N, .step_clk(link.step_clk),
    .mode_in(link.mode_in), .reset_n_in(link.reset_n_in),
    .enable_in(link.enable_in), .phase_a_out(link.phase_a_out),
    .phase_a_inv_out(link.phase_a_inv_out), .phase_b_out(link.phase_b_out),
    .phase_b_inv_out(link.phase_b_inv_out), .STEP_SEEN(step_seen));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) if (step_seen === 1'b1) seen <= seen + 1;

  // ==========
  // Helpers
  // ==========
  task conclude;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task lim(inout int n);
    n++;
    if (n > 3000) begin
      err_total++;
      conclude();
    end
  endtask : lim
  task wr(input logic [3:0] a, input logic [31:0] dd, input logic [1:0] er);
    int n;
    bit b;
    n = 0;
    b = 0;
    @(posedge CLK);
    awaddr <= a; awvalid <= 1'b1; wdata <= dd; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge CLK);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        b = 1;
        bready <= 1'b0;
        check(bresp, er);
      end
      lim(n);
    end
  endtask : wr
  task rd(input logic [3:0] a, input logic [1:0] er);
    int n;
    bit b;
    n = 0;
    b = 0;
    @(posedge CLK);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!b) begin
      @(posedge CLK);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        b = 1;
        d = rdata;
        rready <= 1'b0;
        check(rresp, er);
      end
      lim(n);
    end
  endtask : rd
  task ctl(input int c);
    wr(REG_CTRL_ADDR, 32'(c), RESP_OKAY);
    cdir = c & 1;
    cmode = (c >> 1) & 1;
  endtask : ctl
  task rst_wait;
    int n;
    n = 0;
    do begin
      rd(REG_STATUS_ADDR, RESP_OKAY);
      lim(n);
    end while (d[STAT_RDY_BIT] !== 1'b1);
    repeat (6) @(posedge CLK);
    pos = 0;
    check(ph, 4'h9);
  endtask : rst_wait
  // Odd positions always move by one, so full step realigns to two-on
  task steps(input int k, input bit on);
    int n, s0;
    wr(REG_STEPS_ADDR, 32'(k), RESP_OKAY);
    s0 = seen;
    for (int i = 0; i < k && on; i++) begin
      n = 0;
      while (seen <= s0 + i) begin
        @(posedge CLK);
        lim(n);
      end
      pos = (pos + ((cmode || pos[0]) ? 1 : 2) * (cdir ? -1 : 1)) & 7;
      repeat (4) @(posedge CLK);
      check(ph, tbl[pos]);
    end
    n = 0;
    do begin
      rd(REG_STATUS_ADDR, RESP_OKAY);
      lim(n);
    end while (d[STAT_BUSY_BIT] !== 1'b0);
    if (!on) check(32'(seen - s0), 0);
  endtask : steps

  // ==========
  // Sequence
  // ==========
  initial begin
    seed = 32'h1c024fc2;
    err_total = 0; check_count = 0; pos = 0;
    RST_N = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    rd(REG_CTRL_ADDR, RESP_OKAY);
    check(d, CTRL_RESET_VAL);
    check(ph, 4'h0);
    rst_wait();
    // Every mode and direction; each full-step run entered from an odd position, each half-step run from position 0
    for (int c = 0; c < 4; c++) begin
      ctl(4 + 2 * (1 - c % 2) + c / 2);
      steps(3, 1);
    end
    repeat (6) begin
      v = $random(seed);
      ctl(4 | (v & 3));
      steps(1 + ((v >> 4) & 3), 1);
    end
    ctl(v & 3);
    repeat (5) @(posedge CLK);
    check(ph, 4'h0);
    check(phase_on, 1'b0);
    steps(2, 0);
    ctl(4 | (v & 3));
    repeat (6) @(posedge CLK);
    check(ph, tbl[pos]);
    check(phase_on, 1'b1);
    steps(1, 1);
    ctl(12 | (v & 3));
    repeat (10) @(posedge CLK);
    check(ph, 4'h0);
    rst_wait();
    // A write with the low lane masked must leave the control word alone
    wstrb <= 4'hE;
    wr(REG_CTRL_ADDR, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    repeat (5) @(posedge CLK);
    check(ph, 4'h9);
    rd(REG_CTRL_ADDR, RESP_OKAY);
    check(d, 32'(12 | (v & 3)));
    rd(4'hC, RESP_SLVERR);
    check(d, 32'h0);
    wr(4'hC, 32'h1, RESP_SLVERR);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
